/* File: sadc_ctrl.sv */
// Purpose: Mode controller and channel sequencer of a 64-channel scanning converter.
// Assumes: Avalon-MM slave carries the short I/O window; access class on a sideband.
// Notes:   Channel results are dual-port storage read at any time.
`timescale 1ns/100ps

module sadc_ctrl (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Avalon-MM slave
  input  wire logic [15:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [15:0]          avs_writedata,
  input  wire logic [1:0]           avs_byteenable,
  output logic      [15:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Board select setting, access class and scan length setting
  input  wire logic [7:0]           board_base,
  input  wire logic                 accept_super,
  input  wire logic                 accept_nonpriv,
  input  wire logic                 bus_supervisory,
  input  wire logic [6:0]           scan_length_setting,
  // Converter front end
  input  wire logic [11:0]          adc_data,
  input  wire logic                 adc_busy,
  output sadc_pkg::sadc_front_t     front_end,
  // Interrupt requester unit
  input  wire logic                 iack_in_progress,
  output logic                      irq_request
);
  import sadc_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  sadc_ctl_t          control_status_word;
  sadc_state_t        st;
  sadc_state_t        next_st;
  logic [5:0]         ch;
  logic [5:0]         next_ch;
  logic [5:0]         chsel;
  logic [CNT_W-1:0]   cnt;
  logic               scanning;
  logic               scan_go;
  logic               rand_go;
  logic               new_data;
  logic               scan_done;
  logic [11:0]        rand_result;
  logic [11:0]        chan_result [64];
  logic [15:0]        status_word;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Selection needs both the window base and an accepted access class
  wire        req       = avs_read | avs_write;
  wire        am_ok     = bus_supervisory ? accept_super : accept_nonpriv;
  wire        sel_hit   = (avs_address[15:WIN_LSB] == board_base) && am_ok;
  wire        acc       = req && !avs_waitrequest;
  wire [6:0]  widx      = avs_address[7:1];
  wire        acc_sel   = acc && sel_hit;
  wire        wr_csr    = acc_sel && avs_write && (widx == REG_CSR_IDX);
  wire        wr_chsel  = acc_sel && avs_write && (widx == REG_CHSEL_IDX);
  wire        rd_rand   = acc_sel && avs_read && (widx == REG_RAND_IDX);

  // Byte lanes merge into the current image before fields are taken
  wire [15:0] csr_merged = {avs_byteenable[1] ? avs_writedata[15:8] : status_word[15:8],
                            avs_byteenable[0] ? avs_writedata[7:0]  : status_word[7:0]};
  wire [2:0]  new_mode   = csr_merged[CSR_MODE_LSB +: 3];
  wire [1:0]  new_ref    = csr_merged[CSR_REF_LSB +: 2];
  wire        mode_chg   = wr_csr && (new_mode != control_status_word.mode);
  wire        go_bit     = avs_byteenable[1] && avs_writedata[CHSEL_GO_BIT];

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  // Codes 101 and 110 fall in no group, so nothing starts under them
  wire        is_auto    = (control_status_word.mode == MODE_AUTO) || (control_status_word.mode == MODE_AUTO_TEST);
  wire        is_scan1   = (control_status_word.mode == MODE_SCAN_POLL) || (control_status_word.mode == MODE_SCAN_INT);
  wire        is_rand    = (control_status_word.mode == MODE_RAND_POLL) || (control_status_word.mode == MODE_RAND_INT);
  wire        last_ch    = ({1'b0, ch} == (scan_length_setting - 7'd1));
  wire        storing    = (st == S_STORE) && !iack_in_progress;
  wire        scan_end   = storing && scanning && last_ch;
  wire        rand_end   = storing && !scanning;
  wire        new_mode_scan = (new_mode == MODE_SCAN_POLL) || (new_mode == MODE_SCAN_INT);

  // Status image: control fields read back where they are written
  always_comb begin
    status_word = 16'h0000;
    status_word[CSR_REF_LSB +: 2]  = control_status_word.ref_sel;
    status_word[CSR_MODE_LSB +: 3] = control_status_word.mode;
    status_word[CSR_BUSY_BIT]      = (st != S_IDLE);
    status_word[CSR_NEWDAT_BIT]    = new_data;
    status_word[CSR_DONE_BIT]      = scan_done;
  end

  // Read selection; unmatched or unmapped words read as zero
  wire [15:0] chsel_word = {10'h000, chsel};
  wire [15:0] rd_word    = !sel_hit                   ? 16'h0000 :
                           (widx == REG_CSR_IDX)      ? status_word :
                           (widx == REG_RAND_IDX)     ? {4'h0, rand_result} :
                           (widx == REG_CHSEL_IDX)    ? chsel_word :
                           widx[REG_CHAN_BIT]         ? {4'h0, chan_result[widx[5:0]]} :
                                                        16'h0000;

  // ------------------------------------------------------------
  // Bus handshake
  // ------------------------------------------------------------
  // One wait cycle per access; read data is latched on the first edge and
  // stands while waitrequest is low, so the master samples a stable word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 16'h0000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (req && avs_waitrequest) begin
        avs_readdata <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Reset lands in autoscan, so the board runs with no software at all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      control_status_word.mode    <= MODE_AUTO;
      control_status_word.ref_sel <= REF_RESET;
      chsel       <= CHSEL_RESET;
    end else begin
      if (wr_csr) begin
        control_status_word.mode    <= sadc_mode_t'(new_mode);
        control_status_word.ref_sel <= new_ref;
      end
      if (wr_chsel && avs_byteenable[0]) begin
        chsel <= avs_writedata[CHSEL_LSB +: 6];
      end
    end
  end

  // Start requests wait in IDLE; a mode change into a scan mode arms one pass
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scan_go <= 1'b0;
      rand_go <= 1'b0;
    end else begin
      if (mode_chg) begin
        scan_go <= new_mode_scan;
        rand_go <= 1'b0;
      end else if (st == S_IDLE && next_st == S_SETTLE) begin
        scan_go <= 1'b0;
        rand_go <= 1'b0;
      end else if (wr_chsel && go_bit && st == S_IDLE) begin
        scan_go <= is_scan1;
        rand_go <= is_rand;
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_ch = ch;
    if (mode_chg) begin
      next_st = S_IDLE;
      next_ch = 6'h00;
    end else begin
      case (st)
        S_IDLE: begin
          if (is_auto || (is_scan1 && scan_go)) begin
            next_st = S_SETTLE;
            next_ch = 6'h00;
          end else if (is_rand && rand_go) begin
            next_st = S_SETTLE;
            next_ch = chsel;
          end
        end
        S_SETTLE: begin
          if (cnt == SETTLE_END) begin
            next_st = S_TRACK;
          end
        end
        S_TRACK: begin
          if (cnt == TRACK_END) begin
            next_st = S_CONV;
          end
        end
        S_CONV: begin
          // Slot length fixed by the count; a slow converter stretches it
          if (cnt >= CONV_END && !adc_busy) begin
            next_st = S_STORE;
          end
        end
        S_STORE: begin
          if (!iack_in_progress) begin
            if (!scanning) begin
              next_st = S_IDLE;
            end else if (last_ch) begin
              next_ch = 6'h00;
              next_st = is_auto ? S_SETTLE : S_IDLE;
            end else begin
              next_ch = ch + 6'h01;
              next_st = S_SETTLE;
            end
          end
        end
        default: begin
          next_st = S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st       <= S_IDLE;
      ch       <= 6'h00;
      cnt      <= '0;
      scanning <= 1'b0;
    end else begin
      st <= next_st;
      ch <= next_ch;
      if (next_st == S_SETTLE && st != S_SETTLE) begin
        cnt <= '0;
      end else if (st == S_SETTLE || st == S_TRACK || st == S_CONV) begin
        cnt <= cnt + 10'd1;
      end
      if (st == S_IDLE && next_st == S_SETTLE) begin
        scanning <= is_auto || is_scan1;
      end
    end
  end

  // ------------------------------------------------------------
  // Flags and interrupt request
  // ------------------------------------------------------------
  // A completion in the same cycle as the clearing read keeps the flag set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      new_data    <= 1'b0;
      scan_done   <= 1'b0;
      irq_request <= 1'b0;
      rand_result <= 12'h000;
    end else begin
      if (rand_end) begin
        new_data    <= 1'b1;
        rand_result <= adc_data;
      end else if (rd_rand) begin
        new_data <= 1'b0;
      end
      if (scan_end && is_scan1) begin
        scan_done <= 1'b1;
      end else if (st == S_IDLE && next_st == S_SETTLE && is_scan1) begin
        scan_done <= 1'b0;
      end
      irq_request <= (scan_end && control_status_word.mode == MODE_SCAN_INT) ||
                     (rand_end && control_status_word.mode == MODE_RAND_INT);
    end
  end

  // Result storage has no reset: it is data, and always shows the latest value from a scan
  always_ff @(posedge clk_sys) begin
    if (storing && scanning) begin
      chan_result[ch] <= adc_data;
    end
  end

  // ------------------------------------------------------------
  // Front-end drive
  // ------------------------------------------------------------
  // Idle random mode shows the software channel so the mux settles early
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      front_end <= '0;
    end else begin
      front_end.channel_select_bits <= (is_rand && next_st == S_IDLE) ? chsel : next_ch;
      front_end.ref_sel <= (control_status_word.mode == MODE_AUTO_TEST && next_ch == 6'h00 && scanning)
                           ? control_status_word.ref_sel : 2'h0;
      front_end.track           <= (next_st == S_TRACK);
      front_end.convert_command <= (st == S_TRACK) && (next_st == S_CONV);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_last_store;
    storing && scanning && last_ch;
  endsequence

  sequence s_track_end;
    st == S_TRACK && cnt == TRACK_END && !mode_chg;
  endsequence

  a_wait_then_ack:   assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not acknowledged after one wait cycle");
  a_ack_released:    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge held past the cycle");
  a_nomatch_ignored: assert property (acc && !sel_hit |=> $stable(control_status_word) && $stable(chsel))
    else $error("unselected access changed a register");
  a_convert_pulse:   assert property (s_track_end |=> st == S_CONV ##0 front_end.convert_command
                                      ##1 !front_end.convert_command)
    else $error("convert command not a single pulse at hold");
  a_auto_wrap:       assert property (s_last_store ##0 is_auto && !mode_chg |=>
                                      st == S_SETTLE && ch == 6'h00)
    else $error("autoscan did not restart at channel zero");
  a_scan_stops:      assert property (s_last_store ##0 is_scan1 && !mode_chg |=>
                                      st == S_IDLE && scan_done)
    else $error("single scan did not stop with done flag");
  a_scan_irq:        assert property (s_last_store ##0 control_status_word.mode == MODE_SCAN_INT |=>
                                      irq_request ##1 !irq_request)
    else $error("scan end interrupt request missing");
  a_new_data_set:    assert property (rand_end |=> new_data && rand_result == $past(adc_data))
    else $error("random result not flagged");
  a_iack_holds:      assert property (st == S_STORE && iack_in_progress && !mode_chg |=>
                                      st == S_STORE)
    else $error("store went ahead during acknowledge cycle");
  a_undefined_idle:  assert property (st == S_IDLE && !is_auto && !is_scan1 && !is_rand
                                      && !mode_chg |=> st == S_IDLE)
    else $error("conversion started in undefined mode");
  a_mode_abort:      assert property (mode_chg |=> st == S_IDLE && ch == 6'h00)
    else $error("mode change did not abort the sequencer");

endmodule

/* File: sadc_pkg.sv */
// Purpose: Shared constants and types for the scanning converter mode controller.
// Assumes: 25 MHz system clock; 16-bit registers on a short I/O window.
// Notes:   Times are given in their own unit; cycle counts derive from them.
package sadc_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam real         CLK_MHZ        = 25.0;
  localparam real         CHAN_PERIOD_US = 30.303;  // One channel slot
  localparam real         SETTLE_US      = 2.0;     // Mux settling delay
  localparam real         TRACK_US       = 15.0;    // Track-and-hold acquisition
  // A slot is a longest time, so it rounds down; settle and track round up
  localparam int          CHAN_CYC       = $rtoi(CHAN_PERIOD_US * CLK_MHZ);
  localparam int          SETTLE_CYC     = $rtoi($ceil(SETTLE_US * CLK_MHZ));
  localparam int          TRACK_CYC      = $rtoi($ceil(TRACK_US * CLK_MHZ));
  localparam int          CNT_W          = 10;
  localparam logic [9:0]  SETTLE_END     = 10'(SETTLE_CYC - 1);
  localparam logic [9:0]  TRACK_END      = 10'(SETTLE_CYC + TRACK_CYC - 1);
  localparam logic [9:0]  CONV_END       = 10'(CHAN_CYC - 2);

  // ------------------------------------------------------------
  // Register map (word indices, byte address = 2 x index)
  // ------------------------------------------------------------
  localparam logic [6:0]  REG_CSR_IDX    = 7'h00;
  localparam logic [6:0]  REG_RAND_IDX   = 7'h01;
  localparam logic [6:0]  REG_CHSEL_IDX  = 7'h02;
  localparam int          REG_CHAN_BIT   = 6;       // Index bit 6 set: channel results
  localparam int          WIN_LSB        = 8;       // Window base lies above bit 7

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int          CSR_REF_LSB    = 0;
  localparam int          CSR_MODE_LSB   = 6;
  localparam int          CSR_BUSY_BIT   = 9;
  localparam int          CSR_NEWDAT_BIT = 10;
  localparam int          CSR_DONE_BIT   = 11;
  localparam int          CHSEL_LSB      = 0;
  localparam int          CHSEL_GO_BIT   = 15;
  localparam logic [1:0]  REF_RESET      = 2'h0;
  localparam logic [5:0]  CHSEL_RESET    = 6'h00;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_AUTO      = 3'b000,
    MODE_RAND_POLL = 3'b001,
    MODE_RAND_INT  = 3'b010,
    MODE_SCAN_POLL = 3'b011,
    MODE_SCAN_INT  = 3'b100,
    MODE_AUTO_TEST = 3'b111
  } sadc_mode_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_SETTLE = 3'b001,
    S_TRACK  = 3'b010,
    S_CONV   = 3'b011,
    S_STORE  = 3'b100
  } sadc_state_t;

  typedef struct packed {
    sadc_mode_t mode;
    logic [1:0] ref_sel;
  } sadc_ctl_t;

  typedef struct packed {
    logic [5:0] channel_select_bits;  // Mux address lines
    logic [1:0] ref_sel;              // Channel 0 source: 0 input, 1 high, 2 mid, 3 low
    logic       track;                // High: track, low: hold
    logic       convert_command;      // One-cycle start pulse
  } sadc_front_t;

endpackage

/* File: sadc_adc_model.sv */
// Purpose: Converter front end standing at the far side of the controller.
// Assumes: One conversion per convert pulse; busy for BUSY_CYC cycles.
// Notes:   Result code is built from channel and source so the bench can predict it.
`timescale 1ns/100ps

module sadc_adc_model #(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // Front end in, converter out
  input  wire sadc_pkg::sadc_front_t front_end,
  output logic      [11:0]           adc_data,
  output logic                       adc_busy
);
  import sadc_pkg::*;
  int          cnt;
  logic [11:0] val;
  // Convert pulse starts a busy span; result held once it ends
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      val <= 12'h000;
    end else if (front_end.convert_command) begin
      cnt <= BUSY_CYC;
      val <= {front_end.channel_select_bits, front_end.ref_sel, 4'h9};
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign adc_busy = (cnt > 0);
  // Unsettled lines show inverted data so an early capture cannot match
  assign adc_data = adc_busy ? ~val : val;
endmodule

/* File: tb_sadc_ctrl.sv */
// Purpose: Self-checking bench for the scanning converter mode controller.
// Assumes: A bus access ends only when waitrequest is sampled low.
// Notes:   Scan length 16, the shortest legal scan, keeps the run short.
`timescale 1ns/100ps

module tb_sadc_ctrl;
  import sadc_pkg::*;
  // ------------------------------------------------------------
  // Signals and monitor
  // ------------------------------------------------------------
  localparam logic [7:0] BASE = 8'h3c;
  localparam int         NCH  = 16;
  logic        clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        accept_super = 1'b1, accept_nonpriv = 1'b1, bus_supervisory = 1'b1;
  logic        iack_in_progress = 1'b0, avs_waitrequest, adc_busy, irq_request;
  logic [15:0] avs_address = 16'h0000, avs_writedata = 16'h0000, avs_readdata, q;
  logic [11:0] adc_data;
  logic [1:0]  ref0;
  logic [31:0] lfsr = 32'h010b;
  sadc_front_t front_end;
  int          n_mismatch = 0, n_tests = 0, cyc = 0, last = 0, period = 0, n_irq = 0;
  int          trk = 0, trk_len = 0;
  int          seen[$];
  always #20 clk_sys = ~clk_sys;
  sadc_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(2'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .board_base(BASE), .accept_super(accept_super), .accept_nonpriv(accept_nonpriv),
    .bus_supervisory(bus_supervisory), .scan_length_setting(7'h10), .adc_data(adc_data),
    .adc_busy(adc_busy), .front_end(front_end), .iack_in_progress(iack_in_progress),
    .irq_request(irq_request));
  sadc_adc_model conv (.clk_sys(clk_sys), .rst_n(rst_n), .front_end(front_end),
    .adc_data(adc_data), .adc_busy(adc_busy));
  // Record channel, slot length and channel 0 source at each convert pulse
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (front_end.track === 1'b1) trk <= trk + 1;
    if (front_end.convert_command === 1'b1) begin
      seen.push_back(front_end.channel_select_bits);
      trk_len <= trk;
      trk <= 0;
      period <= cyc - last;
      last <= cyc;
      if (front_end.channel_select_bits === 6'h00) ref0 <= front_end.ref_sel;
    end
    if (irq_request === 1'b1) n_irq <= n_irq + 1;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] ra(input logic [6:0] i);
    return {BASE, i, 1'b0};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [11:0] exp_dat(input logic [5:0] c, input logic [1:0] r);
    return {c, r, 4'h9};
  endfunction
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic poll(input int b, input int lim);
    int t;
    t = 0;
    do begin
      bus(1'b0, ra(7'h00), 16'h0000);
      t++;
    end while (q[b] !== 1'b1 && t < lim);
    if (q[b] !== 1'b1) n_mismatch++;
  endtask
  task automatic wait_for(input int k, input int lim);
    for (int n = 0; n < lim && seen.size() < k; n++) @(posedge clk_sys);
    if (seen.size() < k) n_mismatch++;
    @(negedge clk_sys);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    int i, m, k, n;
    logic [5:0] ch;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Power-up autoscan wraps after channel 15, one slot per channel
    wait_for(18, 20000);
    check("conversions", seen.size(), 18);
    for (i = 0; i < 18; i++) check("scan channel", seen[i], i % NCH);
    check("slot cycles", period, 757);
    check("track cycles", trk_len, 375);
    for (i = 0; i < NCH; i++) begin
      bus(1'b0, ra(7'h40 + 7'(i)), 16'h0000);
      check("result", q, exp_dat(6'(i), 2'h0));
    end
    // Acknowledge cycle across the store lengthens that slot
    wait_for(seen.size() + 1, 2000);
    repeat (300) @(posedge clk_sys);
    iack_in_progress <= 1'b1;
    repeat (200) @(posedge clk_sys);
    iack_in_progress <= 1'b0;
    wait_for(seen.size() + 1, 2000);
    check("held slot", period > 907 && period < 957, 1);
    // Foreign window and refused access class leave the mode alone
    bus(1'b1, {~BASE, 8'h00}, 16'h0140);
    bus(1'b0, {~BASE, 8'h80}, 16'h0000);
    check("foreign read", q, 0);
    accept_nonpriv <= 1'b0;
    bus_supervisory <= 1'b0;
    bus(1'b1, ra(7'h00), 16'h0140);
    bus_supervisory <= 1'b1;
    bus(1'b0, ra(7'h00), 16'h0000);
    check("mode kept", q[8:6], 3'h0);
    accept_nonpriv <= 1'b1;
    // Undefined codes start nothing, even with the go bit
    for (m = 5; m <= 6; m++) begin
      bus(1'b1, ra(7'h00), 16'(m << 6));
      bus(1'b1, ra(7'h02), 16'h8005);
      n = seen.size();
      repeat (1600) @(posedge clk_sys);
      check("idle mode", seen.size(), n);
    end
    // Random poll then random interrupt on random channels
    for (m = 1; m <= 2; m++) begin
      bus(1'b1, ra(7'h00), 16'(m << 6));
      lfsr = lfsr_next(lfsr);
      ch = lfsr[5:0];
      k = n_irq;
      bus(1'b1, ra(7'h02), {10'h200, ch});
      poll(10, 600);
      bus(1'b0, ra(7'h01), 16'h0000);
      check("random result", q, exp_dat(ch, 2'h0));
      bus(1'b0, ra(7'h00), 16'h0000);
      check("new data cleared", q[10], 0);
      check("conversion irq", n_irq - k, m - 1);
    end
    // Scanning poll then scanning interrupt: one pass each
    for (m = 3; m <= 4; m++) begin
      k = n_irq;
      bus(1'b1, ra(7'h00), 16'(m << 6));
      n = seen.size();
      repeat (10) @(posedge clk_sys);
      bus(1'b0, ra(7'h00), 16'h0000);
      check("done cleared", q[11], 0);
      poll(11, 6000);
      repeat (1600) @(posedge clk_sys);
      check("single pass", seen.size() - n, NCH);
      check("scan irq", n_irq - k, m - 3);
    end
    // Mid-run reset with scan_done set returns mode and flags to reset values
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, ra(7'h00), 16'h0000);
    check("reset state", q & 16'h0dc3, 0);
    // Self-test sources on channel 0; only a changed mode restarts at channel 0
    for (i = 0; i < 4; i++) begin
      bus(1'b1, ra(7'h00), 16'h0000);
      bus(1'b1, ra(7'h00), 16'h01c0 | 16'(i));
      wait_for(seen.size() + 1, 2000);
      check("restart channel", seen[$], 0);
      check("channel 0 source", ref0, i);
    end
    end_of_test();
  end
endmodule
